/* File: rtl/buck_gate_pkg.sv */
// Shared constants and types for the buck gate drive control block.
package buck_gate_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 25;
  localparam int LOCKOUT_START_US  = 40;
  localparam int SLEEP_START_US    = 30;
  localparam int MIN_PULSE_NS      = 37;
  localparam int REJECT_PULSE_NS   = 5;
  localparam int BLANK_NS          = 90;
  localparam int LOCKOUT_START_CYC = (LOCKOUT_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_START_CYC   = (SLEEP_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PULSE_CYC     = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REJECT_PULSE_CYC  = (REJECT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC         = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W           = 11;
  localparam int CNT_W             = 4;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL    = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h3;
  localparam int CTRL_DEAD_LSB  = 0;
  localparam int CTRL_SW_OFF    = 4;
  localparam logic [CNT_W-1:0] DEAD_CFG_RESET = 4'h1;
  localparam int EV_READY    = 0;
  localparam int EV_LOCKOUT  = 1;
  localparam int EV_ZC       = 2;
  localparam int EV_STRETCH  = 3;
  localparam int EV_REJECT   = 4;
  localparam int EV_W        = 5;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PS_SHUTDOWN, PS_STARTUP, PS_SLEEP, PS_READY} power_state_t;
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level3_t;
  typedef enum logic [1:0] {DRV_OFF, DRV_HIGH, DRV_LOW, DRV_LOW_ZC} drive_t;

  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } gate_cmd_t;

  typedef struct packed {
    logic supply_undervoltage_lockout;
    logic driver_enable_in;
    logic pwm_upper_threshold;
    logic pwm_lower_threshold;
    logic mode_upper_threshold;
    logic mode_lower_threshold;
    logic zero_current_cutoff;
  } pin_in_t;

  localparam int PIN_W = $bits(pin_in_t);

endpackage

/* File: rtl/pin_sync.sv */
// Three-stage synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // The first stage feeds only the second so metastability cannot leak.
  always_comb
  begin
    next_s    = s;
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s.s2[i] == s.s3[i])
      begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  // Reset value is caught by the clock, so a port value is allowed here.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s <= '{s1: reset_value, s2: reset_value, s3: reset_value, q: reset_value};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sync_out = s.q;

endmodule
`default_nettype wire

/* File: rtl/buck_gate_drive_control.sv */
// Gate command, power sequencing and register port of the buck power stage.
//
// Notes on behaviour
// - Lockout holds gates off; 40 us to ready.
// - Enable low sleeps gates off; 30 us start.
// - Gates follow PWM only when ready.
// - Ready flag pulled low until power ready.
// - Sleep keeps essentials and loads trim fuses.
// - Mode low: high, low, mid both off.
// - Mode high: mid gives blanked diode emulation.
// - Mode mid: low gives blanked diode emulation.
// - Short high pulses stretched to minimum width.
// - PWM levels shorter than 5 ns ignored.
// - Mode select is a three-level input.
`timescale 1ns/1ps
`default_nettype none
module buck_gate_drive_control
  import buck_gate_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst_n,
  input  wire pin_in_t   pins,
  output gate_cmd_t      gate,
  input  wire logic      ready_flag_in,
  output logic           ready_flag_out,
  output logic           ready_flag_oe,
  output logic           low_power_sleep,
  output logic           trim_load_active,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic      reg_write,
  input  wire logic      reg_read,
  output logic     [7:0] reg_rdata,
  output logic           irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    power_state_t       pstate;
    logic [TIMER_W-1:0] timer;
    logic               cold;
    level3_t            pwm_cand;
    logic [CNT_W-1:0]   cand_cnt;
    level3_t            pwm_lvl;
    logic               zc_done;
    gate_cmd_t          gate;
    logic [CNT_W-1:0]   dead_cnt;
    logic [CNT_W-1:0]   stretch_cnt;
    logic [CNT_W-1:0]   blank_cnt;
    logic [CNT_W-1:0]   dead_cfg;
    logic               sw_off;
    logic [EV_W-1:0]    irq_status;
    logic [EV_W-1:0]    irq_mask;
    logic [7:0]         rd_data;
  } core_t;

  core_t s;
  core_t next_s;

  pin_in_t sync;
  pin_in_t sync_reset;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic level3_t level_of(input logic above_upper, input logic above_lower);
    return above_upper ? LVL_HIGH : (above_lower ? LVL_MID : LVL_LOW);
  endfunction

  function automatic drive_t drive_of(input level3_t pwm, input level3_t mode, input logic done);
    drive_t d;
    d = DRV_OFF;
    case (pwm)
      LVL_HIGH:
        d = DRV_HIGH;
      LVL_LOW:
        d = (mode == LVL_MID) ? DRV_LOW_ZC : DRV_LOW;
      LVL_MID:
        d = (mode == LVL_HIGH && !done) ? DRV_LOW_ZC : DRV_OFF;
      default:
        d = DRV_OFF;
    endcase
    if (d == DRV_LOW_ZC && done)
    begin
      d = DRV_OFF;
    end
    return d;
  endfunction

  // Lockout and enable reset to their safe side: locked out, disabled.
  always_comb
  begin
    sync_reset = '0;
    sync_reset.supply_undervoltage_lockout = 1'b1;
  end

  pin_sync #(
    .WIDTH       (PIN_W)
  ) u_pin_sync (
    .clock       (clock),
    .rst_n       (rst_n),
    .async_in    (pins),
    .reset_value (sync_reset),
    .sync_out    (sync)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    level3_t         raw_pwm;
    level3_t         mode;
    drive_t          want;
    logic            run;
    logic            want_high;
    logic            want_low;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    next_s  = s;
    ev      = '0;
    clr     = '0;
    raw_pwm = level_of(sync.pwm_upper_threshold, sync.pwm_lower_threshold);
    // An open pin floats to mid through the analog divider.
    mode    = level_of(sync.mode_upper_threshold, sync.mode_lower_threshold);
    run       = (s.pstate == PS_READY) && !s.sw_off;
    want      = drive_of(s.pwm_lvl, mode, s.zc_done);
    want_high = run && want == DRV_HIGH;
    want_low  = run && (want == DRV_LOW || want == DRV_LOW_ZC);
    next_s.rd_data = 8'h00;

    // Power sequencing.
    case (s.pstate)
      PS_SHUTDOWN:
        if (!sync.supply_undervoltage_lockout)
        begin
          next_s.pstate = PS_STARTUP;
          next_s.timer  = TIMER_W'(LOCKOUT_START_CYC - 1);
          next_s.cold   = 1'b1;
        end
      PS_STARTUP:
        if (!s.cold && !sync.driver_enable_in)
        begin
          next_s.pstate = PS_SLEEP;
        end
        else if (s.timer != '0)
        begin
          next_s.timer = s.timer - 1'b1;
        end
        else if (sync.driver_enable_in)
        begin
          next_s.pstate = PS_READY;
          ev[EV_READY]  = 1'b1;
        end
        else
        begin
          next_s.pstate = PS_SLEEP;
        end
      PS_SLEEP:
        if (sync.driver_enable_in)
        begin
          next_s.pstate = PS_STARTUP;
          next_s.timer  = TIMER_W'(SLEEP_START_CYC - 1);
          next_s.cold   = 1'b0;
        end
      PS_READY:
        if (!sync.driver_enable_in)
        begin
          next_s.pstate = PS_SLEEP;
        end
      default:
        next_s.pstate = PS_SHUTDOWN;
    endcase
    if (sync.supply_undervoltage_lockout && s.pstate != PS_SHUTDOWN)
    begin
      next_s.pstate      = PS_SHUTDOWN;
      ev[EV_LOCKOUT]     = 1'b1;
    end

    // PWM level filter: a level is taken only after it has held.
    if (raw_pwm != s.pwm_cand)
    begin
      next_s.pwm_cand = raw_pwm;
      next_s.cand_cnt = CNT_W'(1);
      if (s.pwm_cand != s.pwm_lvl)
      begin
        ev[EV_REJECT] = 1'b1;
      end
    end
    else if (s.cand_cnt >= CNT_W'(REJECT_PULSE_CYC))
    begin
      next_s.pwm_lvl = s.pwm_cand;
    end
    else
    begin
      next_s.cand_cnt = s.cand_cnt + 1'b1;
    end
    if (next_s.pwm_lvl != s.pwm_lvl)
    begin
      next_s.zc_done = 1'b0;
    end

    // Gate drive.
    if (s.dead_cnt != '0)
    begin
      next_s.dead_cnt = s.dead_cnt - 1'b1;
    end
    if (s.stretch_cnt != '0)
    begin
      next_s.stretch_cnt = s.stretch_cnt - 1'b1;
    end
    if (s.blank_cnt != '0)
    begin
      next_s.blank_cnt = s.blank_cnt - 1'b1;
    end
    if (s.gate.high_side_gate)
    begin
      if (!run)
      begin
        next_s.gate.high_side_gate = 1'b0;
        next_s.dead_cnt            = s.dead_cfg;
      end
      else if (!want_high && s.stretch_cnt == '0)
      begin
        next_s.gate.high_side_gate = 1'b0;
        next_s.dead_cnt            = s.dead_cfg;
      end
      else if (!want_high)
      begin
        ev[EV_STRETCH] = 1'b1;
      end
    end
    else if (s.gate.low_side_gate)
    begin
      if (!want_low)
      begin
        next_s.gate.low_side_gate = 1'b0;
        next_s.dead_cnt           = s.dead_cfg;
      end
      else if (want == DRV_LOW_ZC && s.blank_cnt == '0 && sync.zero_current_cutoff)
      begin
        next_s.gate.low_side_gate = 1'b0;
        next_s.dead_cnt           = s.dead_cfg;
        next_s.zc_done            = 1'b1;
        ev[EV_ZC]                 = 1'b1;
      end
    end
    else if (s.dead_cnt == '0)
    begin
      if (want_high)
      begin
        next_s.gate.high_side_gate = 1'b1;
        next_s.stretch_cnt         = CNT_W'(MIN_PULSE_CYC - 1);
      end
      else if (want_low)
      begin
        next_s.gate.low_side_gate = 1'b1;
        next_s.blank_cnt          = CNT_W'(BLANK_CYC - 1);
      end
    end

    // Register port.
    if (reg_write)
    begin
      case (reg_addr)
        REG_CONTROL:
        begin
          next_s.dead_cfg = reg_wdata[CTRL_DEAD_LSB +: CNT_W];
          next_s.sw_off   = reg_wdata[CTRL_SW_OFF];
        end
        REG_IRQ_STATUS:
          clr = reg_wdata[EV_W-1:0];
        REG_IRQ_MASK:
          next_s.irq_mask = reg_wdata[EV_W-1:0];
        default:
          ;
      endcase
    end
    // A new event in the clearing cycle survives the clear.
    next_s.irq_status = (s.irq_status & ~clr) | ev;
    if (reg_read)
    begin
      case (reg_addr)
        REG_CONTROL:
          next_s.rd_data = {3'h0, s.sw_off, s.dead_cfg};
        REG_STATUS:
          next_s.rd_data = {ready_flag_in, s.pwm_lvl, s.gate, s.pstate, 1'b0};
        REG_IRQ_STATUS:
          next_s.rd_data = {3'h0, s.irq_status};
        REG_IRQ_MASK:
          next_s.rd_data = {3'h0, s.irq_mask};
        default:
          next_s.rd_data = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      s.pstate   <= PS_SHUTDOWN;
      s.pwm_cand <= LVL_LOW;
      s.pwm_lvl  <= LVL_LOW;
      s.dead_cfg <= DEAD_CFG_RESET;
      s.irq_mask <= IRQ_MASK_RESET[EV_W-1:0];
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only one gate can ever be set: turn-on waits for both to be off.
  assign gate             = s.gate;
  assign ready_flag_out   = 1'b0;
  assign ready_flag_oe    = (s.pstate != PS_READY);
  // Sleep keeps sequencing, the PWM filter and the register port alive while the trim fuses load.
  assign low_power_sleep  = (s.pstate == PS_SLEEP);
  assign trim_load_active = (s.pstate == PS_SLEEP);
  assign reg_rdata        = s.rd_data;
  assign irq              = |(s.irq_status & s.irq_mask);

endmodule
`default_nettype wire

/* File: bench/gate_drive_checker.sv */
// Concurrent checks on gate safety, power sequencing and the read port.
`timescale 1ns/1ps
`default_nettype none
module gate_drive_checker
  import buck_gate_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire pin_in_t    pins,
  input wire gate_cmd_t  gate,
  input wire logic       ready_flag_out,
  input wire logic       ready_flag_oe,
  input wire logic       low_power_sleep,
  input wire logic       trim_load_active,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Gap checks assume the non-overlap setting is never below one cycle.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_gates_exclusive: assert property (!(gate.high_side_gate && gate.low_side_gate))
    else $error("both gates on");
  a_lockout_gates_off: assert property (pins.supply_undervoltage_lockout [*8] |-> gate == 2'b00)
    else $error("gate on in lockout");
  a_unready_gates_off: assert property (ready_flag_oe [*3] |-> gate == 2'b00)
    else $error("gate on before ready");
  a_sleep_gates_off: assert property (low_power_sleep [*3] |-> gate == 2'b00 && ready_flag_oe)
    else $error("gate on in sleep");
  a_trim_in_sleep: assert property (trim_load_active == low_power_sleep)
    else $error("trim load outside sleep");
  a_flag_pulls_low: assert property (ready_flag_oe |-> !ready_flag_out)
    else $error("flag not driven low");
  a_lockout_not_ready: assert property (pins.supply_undervoltage_lockout [*8] |-> ready_flag_oe)
    else $error("ready shown in lockout");
  a_high_min_width: assert property ($rose(gate.high_side_gate) |=> gate.high_side_gate)
    else $error("high pulse too short");
  a_dead_low_high: assert property ($fell(gate.low_side_gate) |-> !gate.high_side_gate [*2])
    else $error("no gap before high");
  a_dead_high_low: assert property ($fell(gate.high_side_gate) |-> !gate.low_side_gate [*2])
    else $error("no gap before low");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_unmapped_zero: assert property ($past(reg_read) && $past(reg_addr) > 4'h3 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind buck_gate_drive_control gate_drive_checker u_gate_drive_checker (
  .clock(clock), .rst_n(rst_n), .pins(pins), .gate(gate), .ready_flag_out(ready_flag_out),
  .ready_flag_oe(ready_flag_oe), .low_power_sleep(low_power_sleep),
  .trim_load_active(trim_load_active), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata)
);
`default_nettype wire

/* File: bench/pwm_ctrl_model.sv */
// Controller model that drives the three-level pulse-width line.
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_model
  import buck_gate_pkg::*;
(
  input  wire level3_t level,
  output logic         pwm_upper,
  output logic         pwm_lower
);
  // Comparator pair code 11 high, 01 mid, 00 low; the illegal code 10 is never sent.
  assign pwm_upper = (level == LVL_HIGH);
  assign pwm_lower = (level != LVL_LOW);
endmodule
`default_nettype wire

/* File: bench/buck_gate_drive_control_bench.sv */
// Self-checking bench for the buck gate drive control block.
`timescale 1ns/1ps
`default_nettype none
module buck_gate_drive_control_bench;
  import buck_gate_pkg::*;
  logic        clock, rst_n, lockout, enable, mode_hi, mode_lo, cutoff, flag_in;
  logic        reg_write, reg_read, ready_flag_out, ready_flag_oe, low_power_sleep;
  logic        trim_load_active, irq, pwm_upper, pwm_lower;
  logic [1:0]  md;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd_val;
  logic [31:0] seed;
  level3_t     level, lv;
  gate_cmd_t   gate;
  pin_in_t     pins;
  int          miscompares, comparisons, cycles, n, hi_count, hi_base;

  // The flag line has a pull-up, so it reads high once the block lets go.
  assign flag_in = ready_flag_oe ? 1'b0 : 1'b1;
  assign pins = {lockout, enable, pwm_upper, pwm_lower, mode_hi, mode_lo, cutoff};

  pwm_ctrl_model u_pwm_ctrl_model (.level(level), .pwm_upper(pwm_upper), .pwm_lower(pwm_lower));
  buck_gate_drive_control u_buck_gate_drive_control (
    .clock(clock), .rst_n(rst_n), .pins(pins), .gate(gate), .ready_flag_in(flag_in),
    .ready_flag_out(ready_flag_out), .ready_flag_oe(ready_flag_oe),
    .low_power_sleep(low_power_sleep), .trim_load_active(trim_load_active),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (gate.high_side_gate === 1'b1)
      hi_count++;
    if (cycles == 12000)
    begin
      miscompares++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Zero-current modes keep the low gate on while no cutoff is seen.
  function automatic logic [1:0] exp_gate(input level3_t l, input logic [1:0] m);
    if (l == LVL_HIGH)
      return 2'b10;
    if (l == LVL_LOW)
      return 2'b01;
    return (m == 2'b11) ? 2'b01 : 2'b00;
  endfunction

  task automatic conclude;
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic hold(input level3_t l, input int w, input logic [1:0] e);
    level <= l;
    repeat (w) @(posedge clock);
    #1 chk({6'h00, gate}, {6'h00, e});
  endtask

  task automatic wait_ready(input int lo, input int hi);
    n = 0;
    while (ready_flag_oe !== 1'b0 && n < 3000)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk(8'(n >= lo && n <= hi), 8'h01);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, enable, mode_hi, mode_lo, cutoff, reg_write, reg_read} = 7'h20;
    lockout = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    level = LVL_LOW;
    seed = 32'h806E2C73;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(REG_CONTROL);
    chk(rd_val, 8'h01);
    rd(REG_IRQ_MASK);
    chk(rd_val, IRQ_MASK_RESET);
    wr(4'hF, 8'hFF);
    rd(4'hF);
    chk(rd_val, 8'h00);
    rd(REG_CONTROL);
    chk(rd_val, 8'h01);
    chk({5'h00, gate, ready_flag_oe}, 8'h01);
    lockout <= 1'b0;
    wait_ready(1600, 1612);
    rd(REG_STATUS);
    chk({5'h00, rd_val[7], rd_val[2:1]}, 8'h07);
    rd(REG_IRQ_STATUS);
    chk(rd_val & 8'h01, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h01);
    #1 chk({7'h00, irq}, 8'h01);
    wr(REG_IRQ_STATUS, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h1F);
    hold(LVL_HIGH, 14, 2'b10);
    hold(LVL_MID, 14, 2'b00);
    cutoff <= 1'b1;
    hold(LVL_LOW, 14, 2'b01);
    cutoff <= 1'b0;
    hi_base = hi_count;
    level <= LVL_HIGH;
    @(posedge clock);
    hold(LVL_LOW, 14, 2'b01);
    chk(8'(hi_count - hi_base), 8'h00);
    hi_base = hi_count;
    level <= LVL_HIGH;
    repeat (3) @(posedge clock);
    hold(LVL_LOW, 14, 2'b01);
    chk(8'(hi_count - hi_base), 8'(MIN_PULSE_CYC));
    hold(LVL_HIGH, 14, 2'b10);
    // A one-cycle mid step between high and low must be dropped.
    level <= LVL_MID;
    @(posedge clock);
    hold(LVL_LOW, 14, 2'b01);
    rd(REG_IRQ_STATUS);
    chk(rd_val & 8'h10, 8'h10);
    wr(REG_CONTROL, 8'h12);
    hold(LVL_HIGH, 6, 2'b00);
    wr(REG_CONTROL, 8'h02);
    hold(LVL_HIGH, 14, 2'b10);
    hold(LVL_LOW, 14, 2'b01);
    wr(REG_CONTROL, 8'h01);
    hold(LVL_HIGH, 14, 2'b10);
    {mode_hi, mode_lo} <= 2'b11;
    hold(LVL_MID, 14, 2'b01);
    cutoff <= 1'b1;
    hold(LVL_MID, 10, 2'b00);
    cutoff <= 1'b0;
    hold(LVL_HIGH, 14, 2'b10);
    mode_hi <= 1'b0;
    hold(LVL_LOW, 14, 2'b01);
    cutoff <= 1'b1;
    hold(LVL_LOW, 10, 2'b00);
    cutoff <= 1'b0;
    hold(LVL_MID, 14, 2'b00);
    hold(LVL_HIGH, 14, 2'b10);
    rd(REG_IRQ_STATUS);
    chk(rd_val & 8'h04, 8'h04);
    for (int m = 0; m < 3; m++)
    begin
      hold(LVL_LOW, 14, 2'b01);
      md = (m == 0) ? 2'b00 : (m == 1) ? 2'b01 : 2'b11;
      {mode_hi, mode_lo} <= md;
      repeat (10)
      begin
        seed = lfsr(seed);
        lv = (seed[1:0] == 2'b00) ? LVL_LOW : seed[1] ? LVL_HIGH : LVL_MID;
        hold(lv, 14, exp_gate(lv, md));
      end
    end
    enable <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk({4'h0, low_power_sleep, trim_load_active, gate}, 8'h0C);
    enable <= 1'b1;
    wait_ready(1200, 1212);
    lockout <= 1'b1;
    repeat (12) @(posedge clock);
    #1 chk({5'h00, gate, ready_flag_oe}, 8'h01);
    rd(REG_IRQ_STATUS);
    chk({6'h00, rd_val[1], irq}, 8'h03);
    conclude();
  end
endmodule
`default_nettype wire
